// file: cae_core.sv
// Purpose: Execution core for literal-add and register-add, with
//   branch, two-word, port, timer and table-write handling.
// Assumes: Program memory answers pm_data combinationally for
//   pm_addr; data file answers df_rdata in the cycle after df_re.
`include "cae_defines.svh"
`timescale 1ns/1ns
module cae_core #(
  parameter int IP_W = 20
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  // Register bus
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Program memory
  output logic [IP_W-1:0] pm_addr,
  input wire logic [15:0] pm_data,
  // Data register file
  output logic [11:0] df_addr,
  output logic df_re,
  input wire logic [7:0] df_rdata,
  output logic df_we,
  output logic [7:0] df_wdata,
  // Port pins, timer prescaler, table write
  input wire logic [7:0] port_b_pins,
  input wire logic prescaler_assigned,
  output logic prescaler_clear,
  output logic tbl_wr_start,
  input wire logic tbl_wr_done,
  output logic tbl_wr_busy
);
  cae_pkg::cae_phase_e phase_reg;
  cae_pkg::cae_phase_e phase_next;
  logic [15:0] ir_reg;
  logic [IP_W-1:0] instruction_pointer_reg;
  logic squash_reg;
  logic [7:0] work_reg;
  logic [4:0] status_reg;
  logic [3:0] bank_select_pointer_reg;
  logic [7:0] result_reg;
  logic [4:0] flags_reg;
  logic [7:0] pin_meta_reg;
  logic [7:0] pin_sync_reg;
  logic [7:0] reg_rdata_reg;
  logic df_re_reg;
  logic df_we_reg;
  logic [11:0] df_addr_reg;
  logic psc_clr_reg;
  logic tbl_start_reg;
  logic tbl_busy_reg;
  cae_alu_if alu_bus ();

  cae_alu u_alu (
    .bus(alu_bus)
  );

  ////////////////////////////////////////////////////////////////////
  // Decode of the current instruction word
  wire [15:0] op = squash_reg ? `CAE_OP_NOP : ir_reg;
  wire add_literal_op = (op[15:8] == `CAE_OP_ADD_LIT);
  wire add_register_op = (op[15:10] == `CAE_OP_ADD_REG);
  wire dest_file = add_register_op && op[9];
  wire is_bra = (op[15:11] == `CAE_OP_BRA);
  wire is_bcond = (op[15:11] == `CAE_OP_BCOND);
  wire is_jump = (op[15:8] == `CAE_OP_JUMP);
  wire is_tblwt = (op[15:2] == `CAE_OP_TBLWT);

  // Condition select: Z, C, OV, N; low opcode bit inverts
  wire [3:0] cond_vec = {status_reg[`CAE_BIT_N], status_reg[`CAE_BIT_OV],
    status_reg[`CAE_BIT_C], status_reg[`CAE_BIT_Z]};
  wire cond_true = cond_vec[op[10:9]] ^ op[8];
  wire taken = is_bra || (is_bcond && cond_true) || is_jump;

  // Branch targets relative to the already advanced pointer
  wire [IP_W-1:0] rel_short = {{(IP_W-8){op[7]}}, op[7:0]};
  wire [IP_W-1:0] rel_long = {{(IP_W-11){op[10]}}, op[10:0]};
  wire [IP_W-1:0] jump_abs = {pm_data[11:0], op[7:0]};
  wire [IP_W-1:0] target = is_jump ? jump_abs :
    instruction_pointer_reg + (is_bra ? rel_long : rel_short);

  // Operand address: access bank split or bank pointer as high bits
  wire [11:0] acc_addr = (op[7:0] < `CAE_ACC_SPLIT) ? {4'h0, op[7:0]} :
    {`CAE_ACC_HIGH, op[7:0]};
  wire [11:0] f_addr = op[8] ? {bank_select_pointer_reg, op[7:0]} :
    acc_addr;

  // Port reads come from the pins, never the output latch
  wire [7:0] file_val = (df_addr_reg == `CAE_ADDR_PORT_B) ?
    pin_sync_reg : df_rdata;
  assign alu_bus.a = work_reg;
  assign alu_bus.b = add_literal_op ? op[7:0] : file_val;
  wire [4:0] alu_flags = {alu_bus.n, alu_bus.ov, alu_bus.z, alu_bus.dc,
    alu_bus.c};
  wire is_add = add_literal_op || add_register_op;
  wire hits_timer = dest_file && (df_addr_reg == `CAE_ADDR_TIMER0);

  ////////////////////////////////////////////////////////////////////
  // Phase sequencer, one step per enabled clock
  always_comb begin
    case (phase_reg)
      cae_pkg::PH_Q1: phase_next = cae_pkg::PH_Q2;
      cae_pkg::PH_Q2: phase_next = cae_pkg::PH_Q3;
      cae_pkg::PH_Q3: phase_next = cae_pkg::PH_Q4;
      cae_pkg::PH_Q4: phase_next = cae_pkg::PH_Q1;
      default: phase_next = cae_pkg::PH_Q1;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase_reg <= cae_pkg::PH_Q1;
    end else if (ce) begin
      phase_reg <= phase_next;
    end
  end

  // Two-stage pin synchroniser; only the second stage is read
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_meta_reg <= 8'h00;
      pin_sync_reg <= 8'h00;
    end else if (ce) begin
      pin_meta_reg <= port_b_pins;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Q1 decode issues the read; Q2 holds it; Q3 latches the result
  always_ff @(posedge core_clk) begin
    if (srst) begin
      df_addr_reg <= 12'h000;
      df_re_reg <= 1'b0;
      df_we_reg <= 1'b0;
      result_reg <= 8'h00;
      flags_reg <= 5'h00;
      psc_clr_reg <= 1'b0;
    end else if (ce) begin
      df_re_reg <= (phase_reg == cae_pkg::PH_Q1) && add_register_op;
      df_we_reg <= 1'b0;
      psc_clr_reg <= 1'b0;
      if (phase_reg == cae_pkg::PH_Q1) begin
        df_addr_reg <= f_addr;
      end
      if (phase_reg == cae_pkg::PH_Q3) begin
        result_reg <= alu_bus.sum;
        flags_reg <= alu_flags;
        df_we_reg <= dest_file;
        psc_clr_reg <= hits_timer && prescaler_assigned;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Q4: write destination, then fetch or redirect
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ir_reg <= `CAE_OP_NOP;
      instruction_pointer_reg <= `CAE_RST_IP;
      squash_reg <= 1'b1;
    end else if (ce && phase_reg == cae_pkg::PH_Q4) begin
      if (taken) begin
        instruction_pointer_reg <= target;
        squash_reg <= 1'b1;
      end else if (is_tblwt) begin
        // Fetch waits one instruction cycle (four clocks) so the next word is not lost
        squash_reg <= 1'b1;
      end else begin
        ir_reg <= pm_data;
        instruction_pointer_reg <= instruction_pointer_reg + 1'b1;
        squash_reg <= 1'b0;
      end
    end
  end

  // Work and status; the core's Q4 write wins over a bus write
  wire core_wr = ce && phase_reg == cae_pkg::PH_Q4 && is_add;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      work_reg <= `CAE_RST_WORK;
      status_reg <= `CAE_RST_STATUS;
      bank_select_pointer_reg <= `CAE_RST_BANK;
    end else if (ce) begin
      if (reg_wr && reg_addr == `CAE_OFS_WORK) begin
        work_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == `CAE_OFS_STATUS) begin
        status_reg <= reg_wdata[4:0];
      end
      if (reg_wr && reg_addr == `CAE_OFS_BANK) begin
        bank_select_pointer_reg <= reg_wdata[3:0];
      end
      if (core_wr) begin
        status_reg <= flags_reg;
        if (!dest_file) begin
          work_reg <= result_reg;
        end
      end
    end
  end

  // Table write: once started, only completion ends it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tbl_start_reg <= 1'b0;
      tbl_busy_reg <= 1'b0;
    end else if (ce) begin
      tbl_start_reg <= 1'b0;
      if (tbl_busy_reg) begin
        tbl_busy_reg <= !tbl_wr_done;
      end else if (phase_reg == cae_pkg::PH_Q4 && is_tblwt) begin
        tbl_start_reg <= 1'b1;
        tbl_busy_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register bus read data, one cycle after the strobe
  wire [7:0] rd_mux = (reg_addr == `CAE_OFS_WORK) ? work_reg :
    (reg_addr == `CAE_OFS_STATUS) ? {3'h0, status_reg} :
    (reg_addr == `CAE_OFS_BANK) ? {4'h0, bank_select_pointer_reg} :
    {7'h00, tbl_busy_reg};
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata_reg <= 8'h00;
    end else if (ce) begin
      reg_rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = reg_rdata_reg;
  assign pm_addr = instruction_pointer_reg;
  assign df_addr = df_addr_reg;
  assign df_re = df_re_reg;
  assign df_we = df_we_reg;
  assign df_wdata = result_reg;
  assign prescaler_clear = psc_clr_reg;
  assign tbl_wr_start = tbl_start_reg;
  assign tbl_wr_busy = tbl_busy_reg;
endmodule // cae_core

// file: cae_defines.svh
// Purpose: Constants for the add-instruction execution core.
// Assumes: Included by its bare name; definitions only.
// Notes: Offsets, field positions, opcodes, reset values.
`ifndef CAE_DEFINES_SVH
`define CAE_DEFINES_SVH
// Register bus offsets
`define CAE_OFS_WORK 2'h0
`define CAE_OFS_STATUS 2'h1
`define CAE_OFS_BANK 2'h2
`define CAE_OFS_TBL 2'h3
// Status flag bit positions
`define CAE_BIT_C 0
`define CAE_BIT_DC 1
`define CAE_BIT_Z 2
`define CAE_BIT_OV 3
`define CAE_BIT_N 4
// Reset values
`define CAE_RST_WORK 8'h00
`define CAE_RST_STATUS 5'h00
`define CAE_RST_BANK 4'h0
`define CAE_RST_IP 20'h00000
// Opcode fields
`define CAE_OP_ADD_LIT 8'h0F
`define CAE_OP_ADD_REG 6'h09
`define CAE_OP_BRA 5'h1A
`define CAE_OP_BCOND 5'h1C
`define CAE_OP_JUMP 8'hEF
`define CAE_OP_SECOND 4'hF
`define CAE_OP_TBLWT 14'h0003
`define CAE_OP_NOP 16'h0000
// Data file addresses
`define CAE_ACC_SPLIT 8'h80
`define CAE_ACC_HIGH 4'hF
`define CAE_ADDR_PORT_B 12'hF81
`define CAE_ADDR_TIMER0 12'hFD6
`endif

// file: cae_pkg.sv
// Purpose: Shared types of the add-instruction execution core.
// Assumes: Nothing beyond the defines header.
// Notes: Phase codes are one-hot.
package cae_pkg;
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } cae_phase_e;
endpackage

// file: cae_alu_if.sv
// Purpose: Operand and result bundle between core and adder.
// Assumes: Combinational use only.
// Notes: One modport for each side.
`timescale 1ns/1ns
interface cae_alu_if;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] sum;
  logic c;
  logic dc;
  logic z;
  logic ov;
  logic n;
  modport core (output a, output b, input sum, input c, input dc,
    input z, input ov, input n);
  modport alu (input a, input b, output sum, output c, output dc,
    output z, output ov, output n);
endinterface // cae_alu_if

// file: cae_alu.sv
// Purpose: 8-bit adder with the five arithmetic flags.
// Assumes: Pure combinational logic.
// Notes: Overflow is signed overflow of the two operands.
`timescale 1ns/1ns
module cae_alu (
  cae_alu_if.alu bus
);
  wire [8:0] full;
  wire [4:0] low;

  // Full and low-nibble sums for carry and digit carry
  assign full = {1'b0, bus.a} + {1'b0, bus.b};
  assign low = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]};
  assign bus.sum = full[7:0];
  assign bus.c = full[8];
  assign bus.dc = low[4];
  assign bus.z = (full[7:0] == 8'h00);
  assign bus.n = full[7];
  // Same-sign operands giving an opposite-sign sum
  assign bus.ov = (bus.a[7] == bus.b[7]) && (full[7] != bus.a[7]);
endmodule // cae_alu

// file: cae_core_props.sv
// Purpose: Port timing checks for the add-instruction execution core.
// Assumes: ce held high, one clock domain.
// Notes: Bound to every cae_core instance.
`timescale 1ns/1ns
module cae_core_props #(
  parameter int IP_W = 20
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [IP_W-1:0] pm_addr,
  input wire logic [11:0] df_addr,
  input wire logic df_re,
  input wire logic df_we,
  input wire logic prescaler_assigned,
  input wire logic prescaler_clear,
  input wire logic tbl_wr_start,
  input wire logic tbl_wr_done,
  input wire logic tbl_wr_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  // Operand address must not move while read and write-back are pending
  sequence s_hold;
    $stable(df_addr) [*2];
  endsequence
  property p_hold; df_re |=> s_hold; endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_re_one; df_re |=> !df_re; endproperty
  a_re_one: assert property (p_re_one) else $error("long read");
  property p_we_late; df_we |-> $past(df_re, 2); endproperty
  a_we_late: assert property (p_we_late) else $error("early write");
  property p_step; df_we |=> pm_addr == $past(pm_addr) + 1'b1; endproperty
  a_step: assert property (p_step) else $error("pointer step");
  // Prescaler clear only beside a timer write-back, and with each one while the prescaler is assigned
  property p_psc_why; prescaler_clear |-> df_we && df_addr == 12'hFD6;
  endproperty
  a_psc_why: assert property (p_psc_why) else $error("stray clear");
  property p_psc_need;
    df_we && df_addr == 12'hFD6 && prescaler_assigned |-> prescaler_clear;
  endproperty
  a_psc_need: assert property (p_psc_need) else $error("no clear");
  // A launched table write is never dropped early
  property p_busy; tbl_wr_busy && !tbl_wr_done |=> tbl_wr_busy; endproperty
  a_busy: assert property (p_busy) else $error("write aborted");
  property p_start; tbl_wr_start |=> !tbl_wr_start; endproperty
  a_start: assert property (p_start) else $error("long start");
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stale read");
endmodule // cae_core_props
bind cae_core cae_core_props #(.IP_W(IP_W)) u_props (.*);

// file: cae_mem_model.sv
// Purpose: Program memory and data file beside the core.
// Assumes: Program loaded by the bench before reset release.
// Notes: Read data not asked for shows the inverse of the last value.
`timescale 1ns/1ns
module cae_mem_model (
  input wire logic clk,
  input wire logic [19:0] pm_addr,
  output logic [15:0] pm_data,
  input wire logic [11:0] df_addr,
  input wire logic df_re,
  output logic [7:0] df_rdata = 8'h00,
  input wire logic df_we,
  input wire logic [7:0] df_wdata
);
  logic [15:0] prog [0:255];
  logic [7:0] file [0:4095];
  // Small program space wraps; enough for the bench program
  assign pm_data = prog[pm_addr[7:0]];
  // Answer one cycle after the strobe, otherwise toggle so nothing lingers
  always @(posedge clk) begin
    df_rdata <= df_re ? file[df_addr] : ~df_rdata;
    if (df_we) begin
      file[df_addr] <= df_wdata;
    end
  end
endmodule // cae_mem_model

// file: testbench.sv
// Purpose: Runs a short add program and checks results by bus and memory.
// Assumes: ce and pins tied; prescaler assignment set per run.
// Notes: Table write completion is driven here to test holding.
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module testbench;
  logic core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic tbl_wr_done = 1'b0, tbl_wr_busy, psc, tbl_start;
  logic psc_asg = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, df_rdata, df_wdata;
  logic [19:0] pm_addr;
  logic [15:0] pm_data;
  logic [11:0] df_addr;
  logic df_re, df_we;
  int err_total = 0, comparisons = 0, psc_cnt = 0, cyc = 0, tbl_cnt = 0;
  logic [15:0] prog [0:16] = '{16'h0F17, 16'h2620, 16'h2420, 16'h2781,
    16'h26D6, 16'h2481, 16'hF123, 16'h000C, 16'hEF0B, 16'hF000, 16'h0F80,
    16'h0F01, 16'hE101, 16'h0F80, 16'hE001, 16'h0F01, 16'hD7FF};
  cae_core DUT (.core_clk(core_clk), .srst(srst), .ce(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pm_addr(pm_addr),
    .pm_data(pm_data), .df_addr(df_addr), .df_re(df_re),
    .df_rdata(df_rdata), .df_we(df_we), .df_wdata(df_wdata),
    .port_b_pins(8'h33), .prescaler_assigned(psc_asg),
    .prescaler_clear(psc), .tbl_wr_start(tbl_start),
    .tbl_wr_done(tbl_wr_done), .tbl_wr_busy(tbl_wr_busy));
  cae_mem_model MEM (.clk(core_clk), .pm_addr(pm_addr), .pm_data(pm_data),
    .df_addr(df_addr), .df_re(df_re), .df_rdata(df_rdata), .df_we(df_we),
    .df_wdata(df_wdata));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, pulse counting and hang guard
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    psc_cnt <= psc_cnt + int'(psc);
    tbl_cnt <= tbl_cnt + int'(tbl_start);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      conclude();
    end
  end
  // Bus write: one strobe cycle
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Bus read: data valid only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic conclude();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // One program run from reset: adds, bank and port operands, lone word,
  // table write, jump, taken and untaken tests, final loop at word 16
  task automatic run_prog(input logic asg, input int psc_exp,
    input int tbl_exp);
    @(posedge core_clk);
    srst <= 1'b1;
    psc_asg <= asg;
    // Let a pending write strobe drain before reloading the file
    repeat (2) @(posedge core_clk);
    MEM.file[12'h020] = 8'hC2;
    MEM.file[12'h281] = 8'h05;
    MEM.file[12'hFD6] = 8'h00;
    MEM.file[12'hF81] = 8'h44;
    repeat (9) @(posedge core_clk);
    srst <= 1'b0;
    wr(2'h2, 8'hF2);
    repeat (400) @(posedge core_clk);
    rd(2'h0, 8'h25);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h02);
    `CHK(MEM.file[12'h020], 8'hD9)
    `CHK(MEM.file[12'h281], 8'hF5)
    `CHK(MEM.file[12'hFD6], 8'hF0)
    `CHK(MEM.file[12'hF81], 8'h44)
    `CHK(psc_cnt, psc_exp)
    `CHK(pm_addr[19:1], 19'h00008)
    `CHK(tbl_wr_busy, 1'b1)
    `CHK(tbl_cnt, tbl_exp)
    wr(2'h3, 8'h00);
    rd(2'h3, 8'h01);
    @(posedge core_clk);
    tbl_wr_done <= 1'b1;
    @(posedge core_clk);
    tbl_wr_done <= 1'b0;
    rd(2'h3, 8'h00);
  endtask
  initial begin
    for (int i = 0; i < 256; i++) begin
      MEM.prog[i] = (i < 17) ? prog[i] : 16'h0000;
    end
    run_prog(1'b1, 1, 1);
    // Mid-run reset; an unassigned prescaler must see no clear
    run_prog(1'b0, 1, 2);
    conclude();
  end
endmodule // testbench
